/* File: rtl/acx_unit.v */
// accumulator extract unit: pipeline operation port, accumulators and apb registers
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`include "acx_regs.vh"

module acx_unit #(
  parameter ACC_NUM = 4
) (
  // clock and reset
  input wire clk_sys,
  input wire rst_n,
  // apb slave
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // operation request from the pipeline
  input wire op_valid,
  input wire [2:0] op_code,
  input wire [1:0] acc_select,
  input wire [31:0] source_reg,
  input wire [4:0] op_shift_imm,
  // writeback to the pipeline
  output wire res_valid,
  output wire [31:0] dest_reg,
  output wire res_extract_fail,
  // interrupt
  output wire irq
);

  // reset synchroniser
  // asserts at once, releases two edges later so no flop misses recovery
  reg rst_meta_r;
  reg rst_sync_r;
  wire rst_sys_n;

  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  assign rst_sys_n = rst_sync_r;

  // state
  reg [31:0] acc_high_word_r [0:ACC_NUM-1];
  reg [31:0] acc_low_word_r [0:ACC_NUM-1];
  reg [31:0] dsp_ctrl_reg_r;
  reg [31:0] dsp_ctrl_reg_nxt;
  reg [1:0] irq_stat_r;
  reg [1:0] irq_stat_nxt;
  reg [1:0] irq_mask_r;
  reg [1:0] irq_mask_nxt;
  reg irq_r;
  reg pready_r;
  reg pslverr_r;
  reg [31:0] prdata_r;
  reg res_valid_r;
  reg [31:0] dest_reg_r;
  reg res_fail_r;

  // apb decode
  wire bus_access;
  wire bus_commit;
  wire bus_wr;
  wire bus_rd;
  wire [7:0] acc_off;
  wire [1:0] acc_idx;
  wire acc_hit;
  wire ofs_hit;
  wire addr_ok;

  assign bus_access = psel & penable;
  // the transfer completes at the edge that samples pready high
  assign bus_commit = bus_access & pready_r;
  assign bus_wr = bus_commit & pwrite;
  assign bus_rd = bus_commit & ~pwrite;
  assign acc_off = paddr - `ACX_OFS_ACC_BASE;
  assign acc_idx = acc_off[4:3];
  assign acc_hit = (paddr >= `ACX_OFS_ACC_BASE) && (paddr <= `ACX_OFS_ACC_LAST);
  assign ofs_hit = (paddr == `ACX_OFS_CTRL) || (paddr == `ACX_OFS_IRQ_STAT) ||
    (paddr == `ACX_OFS_IRQ_MASK) || (paddr == `ACX_OFS_RESULT) || acc_hit;
  // misaligned offsets are refused rather than rounded down
  assign addr_ok = ofs_hit && (paddr[1:0] == 2'h0);

  // operation decode
  wire is_bitf;
  wire is_word;
  wire op_fire;
  wire dec_en;
  wire [4:0] bf_size;
  wire round_en;
  wire sat_en;
  wire [63:0] acc_sel_val;

  assign is_bitf = (op_code == `ACX_OP_EXT_VAR) || (op_code == `ACX_OP_EXT_VAR_DEC) ||
    (op_code == `ACX_OP_EXT_FIX_DEC);
  assign is_word = (op_code == `ACX_OP_WORD) || (op_code == `ACX_OP_WORD_RND) ||
    (op_code == `ACX_OP_WORD_RND_SAT);
  // unknown codes are dropped silently, never trapped
  assign op_fire = op_valid & (is_bitf | is_word);
  assign dec_en = (op_code == `ACX_OP_EXT_VAR_DEC) || (op_code == `ACX_OP_EXT_FIX_DEC);
  // fixed-size decrement takes its size from the immediate field
  assign bf_size = (op_code == `ACX_OP_EXT_FIX_DEC) ? op_shift_imm : source_reg[4:0];
  assign round_en = (op_code == `ACX_OP_WORD_RND) || (op_code == `ACX_OP_WORD_RND_SAT);
  assign sat_en = (op_code == `ACX_OP_WORD_RND_SAT);
  // accumulators are only read here, never written by an operation
  assign acc_sel_val = {acc_high_word_r[acc_select], acc_low_word_r[acc_select]};

  // datapaths
  wire [31:0] bf_data;
  wire bf_ok;
  wire [5:0] bf_pos_after;
  wire [31:0] ws_data;
  wire ws_ovf;

  acx_bitfield u_bitfield (
    .acc_val(acc_sel_val),
    .start_pos(dsp_ctrl_reg_r[`ACX_POS_MSB:0]),
    .field_size(bf_size),
    .field_data(bf_data),
    .field_ok(bf_ok),
    .pos_after(bf_pos_after)
  );

  acx_word_shift u_word_shift (
    .acc_val(acc_sel_val),
    .shift_amt(op_shift_imm),
    .round_en(round_en),
    .sat_en(sat_en),
    .word_data(ws_data),
    .word_ovf(ws_ovf)
  );

  // control register next value
  always @*
  begin
    dsp_ctrl_reg_nxt = dsp_ctrl_reg_r;
    if (bus_wr && (paddr == `ACX_OFS_CTRL))
    begin
      dsp_ctrl_reg_nxt = pwdata;
    end
    // an operation in the same cycle overrides the fields it owns
    if (op_fire && is_bitf)
    begin
      dsp_ctrl_reg_nxt[`ACX_EXTRACT_FAIL_BIT] = ~bf_ok;
      if (dec_en && bf_ok)
      begin
        dsp_ctrl_reg_nxt[`ACX_POS_MSB:0] = bf_pos_after;
      end
    end
    if (op_fire && is_word && ws_ovf)
    begin
      dsp_ctrl_reg_nxt[`ACX_OVF_FLAG_BIT] = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
    begin
      dsp_ctrl_reg_r <= `ACX_CTRL_RST;
    end
    else
    begin
      dsp_ctrl_reg_r <= dsp_ctrl_reg_nxt;
    end
  end

  // writeback, committed together with the flag update
  always @(posedge clk_sys or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
    begin
      res_valid_r <= 1'b0;
      dest_reg_r <= 32'h0000_0000;
      res_fail_r <= 1'b0;
    end
    else
    begin
      res_valid_r <= op_fire;
      if (op_fire)
      begin
        if (is_bitf)
        begin
          // a failed extraction returns zero rather than stale data
          dest_reg_r <= bf_ok ? bf_data : 32'h0000_0000;
          res_fail_r <= ~bf_ok;
        end
        else
        begin
          dest_reg_r <= ws_data;
          res_fail_r <= 1'b0;
        end
      end
    end
  end

  // accumulators, loaded by software only
  integer i;

  always @(posedge clk_sys or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
    begin
      for (i = 0; i < ACC_NUM; i = i + 1)
      begin
        acc_high_word_r[i] <= 32'h0000_0000;
        acc_low_word_r[i] <= 32'h0000_0000;
      end
    end
    else if (bus_wr && acc_hit && (paddr[1:0] == 2'h0))
    begin
      if (acc_off[2])
      begin
        acc_high_word_r[acc_idx] <= pwdata;
      end
      else
      begin
        acc_low_word_r[acc_idx] <= pwdata;
      end
    end
  end

  // interrupt status, read clears only what the read returned
  reg [1:0] ev_w;
  reg [1:0] clr_w;

  always @*
  begin
    ev_w = 2'h0;
    ev_w[`ACX_IRQ_FAIL_BIT] = op_fire & is_bitf & ~bf_ok;
    ev_w[`ACX_IRQ_OVF_BIT] = op_fire & is_word & ws_ovf;
    clr_w = 2'h0;
    if (bus_rd && (paddr == `ACX_OFS_IRQ_STAT))
    begin
      clr_w = prdata_r[1:0];
    end
    // a new event wins over the clear in the same cycle
    irq_stat_nxt = (irq_stat_r & ~clr_w) | ev_w;
    // new mask counts from the edge that writes it
    irq_mask_nxt = irq_mask_r;
    if (bus_wr && (paddr == `ACX_OFS_IRQ_MASK))
    begin
      irq_mask_nxt = pwdata[1:0];
    end
  end

  always @(posedge clk_sys or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
    begin
      irq_stat_r <= `ACX_IRQ_RST;
      irq_mask_r <= `ACX_IRQ_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      irq_r <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end

  // apb read data and completion
  reg [31:0] rd_mux;

  always @*
  begin
    rd_mux = 32'h0000_0000;
    case (paddr)
      `ACX_OFS_CTRL:
      begin
        rd_mux = dsp_ctrl_reg_r;
      end
      `ACX_OFS_IRQ_STAT:
      begin
        rd_mux = {30'h0, irq_stat_r};
      end
      `ACX_OFS_IRQ_MASK:
      begin
        rd_mux = {30'h0, irq_mask_r};
      end
      `ACX_OFS_RESULT:
      begin
        rd_mux = dest_reg_r;
      end
      default:
      begin
        if (acc_hit)
        begin
          rd_mux = acc_off[2] ? acc_high_word_r[acc_idx] : acc_low_word_r[acc_idx];
        end
      end
    endcase
  end

  // one wait state keeps pready and prdata straight from flops
  always @(posedge clk_sys or negedge rst_sys_n)
  begin
    if (!rst_sys_n)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end
    else
    begin
      pready_r <= bus_access & ~pready_r;
      // writes and refused accesses return zero, never stale data
      if (bus_access && !pready_r)
      begin
        pslverr_r <= ~addr_ok;
        prdata_r <= (pwrite || !addr_ok) ? 32'h0000_0000 : rd_mux;
      end
      else
      begin
        pslverr_r <= 1'b0;
      end
    end
  end

  // outputs
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign res_valid = res_valid_r;
  assign dest_reg = dest_reg_r;
  assign res_extract_fail = res_fail_r;
  assign irq = irq_r;

endmodule

/* File: rtl/acx_regs.vh */
// register offsets, field positions and reset values of the accumulator extract unit
//
// Functional notes
// - variable extracts take size from source_reg[4:0]; size+1 bits extracted
// - extraction starts at the position field, bits 5..0 of dsp_ctrl_reg
// - bits pos down to pos-size land zero-extended in the destination
// - acc_select 0..3 picks one of four 64-bit accumulators; 0 is high/low pair
// - extract operations never modify the selected accumulator
// - extraction valid only when pos-(size+1) >= -1, otherwise failed
// - decrementing extract lowers pos by size+1 when valid, keeps it when failed
// - every bitfield extract writes extract_fail_flag at bit 14: one failed, zero valid; word extracts leave it
// - non-decrementing variable extract leaves the position field alone
// - word extract: arithmetic right shift of accumulator, low 32 bits out
// - rounding variants add one at the most significant discarded bit
// - saturating variant clamps overflow to 7FFFFFFF or 80000000 by sign
// - bit 23 set when unrounded or rounded value overflows 32 signed bits
// - no operand-dependent exception is raised by any extract
// - word extract shift amount comes from the instruction immediate
// - bit 23 belongs to the overflow field: set only, never cleared by ops
`ifndef ACX_REGS_VH
`define ACX_REGS_VH

// apb register offsets
`define ACX_OFS_CTRL 8'h00
`define ACX_OFS_IRQ_STAT 8'h04
`define ACX_OFS_IRQ_MASK 8'h08
`define ACX_OFS_RESULT 8'h0C
`define ACX_OFS_ACC_BASE 8'h10
`define ACX_OFS_ACC_LAST 8'h2C

// dsp_ctrl_reg fields
`define ACX_POS_MSB 5
`define ACX_EXTRACT_FAIL_BIT 14
`define ACX_OVF_FLAG_BIT 23
`define ACX_CTRL_RST 32'h0000_0000

// interrupt status bits
`define ACX_IRQ_FAIL_BIT 0
`define ACX_IRQ_OVF_BIT 1
`define ACX_IRQ_RST 2'h0

// operation codes
`define ACX_OP_EXT_VAR 3'h0
`define ACX_OP_EXT_VAR_DEC 3'h1
`define ACX_OP_EXT_FIX_DEC 3'h2
`define ACX_OP_WORD 3'h3
`define ACX_OP_WORD_RND 3'h4
`define ACX_OP_WORD_RND_SAT 3'h5

// saturation limits
`define ACX_SAT_POS 32'h7FFF_FFFF
`define ACX_SAT_NEG 32'h8000_0000

`endif

/* File: rtl/acx_bitfield.v */
// bitfield extraction from a 64-bit accumulator at a given start position
module acx_bitfield (
  // operands
  input wire [63:0] acc_val,
  input wire [5:0] start_pos,
  input wire [4:0] field_size,
  // results
  output wire [31:0] field_data,
  output wire field_ok,
  output wire [5:0] pos_after
);
  wire [5:0] low_pos;
  wire [63:0] shifted_w;
  wire [5:0] width_w;
  wire [32:0] mask_w;

  // pos-(size+1) >= -1 is the same as pos >= size
  assign field_ok = (start_pos >= {1'b0, field_size});
  assign low_pos = start_pos - {1'b0, field_size};
  assign shifted_w = acc_val >> low_pos;
  assign width_w = {1'b0, field_size} + 6'h01;
  assign mask_w = (33'h1 << width_w) - 33'h1;
  assign field_data = shifted_w[31:0] & mask_w[31:0];
  assign pos_after = low_pos - 6'h01;
endmodule

/* File: rtl/acx_word_shift.v */
// word extraction with arithmetic right shift, rounding and saturation
`include "acx_regs.vh"
module acx_word_shift (
  // operands
  input wire [63:0] acc_val,
  input wire [4:0] shift_amt,
  input wire round_en,
  input wire sat_en,
  // results
  output wire [31:0] word_data,
  output wire word_ovf
);
  wire [64:0] shifted_w;
  wire [64:0] rounded_w;
  wire ovf_plain;
  wire ovf_round;
  wire [31:0] pick_w;

  // guard bit below the result keeps the first discarded bit
  assign shifted_w = $signed({acc_val, 1'b0}) >>> shift_amt;
  assign rounded_w = shifted_w + 65'h1;
  assign ovf_plain = ~((&shifted_w[64:32]) | ~(|shifted_w[64:32]));
  assign ovf_round = ~((&rounded_w[64:32]) | ~(|rounded_w[64:32]));
  // rounded check counts for the plain variant too
  assign word_ovf = ovf_plain | ovf_round;
  assign pick_w = round_en ? rounded_w[32:1] : shifted_w[32:1];
  assign word_data = (sat_en & ovf_round) ?
    (rounded_w[64] ? `ACX_SAT_NEG : `ACX_SAT_POS) : pick_w;
endmodule

/* File: tb/acx_unit_monitor.sv */
// port assertions of the accumulator extract unit
module acx_unit_monitor (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // pipeline
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic [31:0] source_reg,
  input wire logic res_valid,
  input wire logic [31:0] dest_reg,
  input wire logic res_extract_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_op_answer: assert property (op_valid && op_code <= 3'h5 |=> res_valid)
    else $error("no result after a legal operation");
  a_res_cause: assert property (res_valid |-> $past(op_valid) && $past(op_code) <= 3'h5)
    else $error("result without a legal operation");
  a_dest_hold: assert property (!op_valid |=> $stable(dest_reg) && $stable(res_extract_fail))
    else $error("result changed without an operation");
  a_fail_zero: assert property (res_valid && res_extract_fail |-> dest_reg == 32'h0)
    else $error("failed extraction gave nonzero data");
  a_zero_ext: assert property (op_valid && op_code <= 3'h1 && source_reg[4:0] != 5'h1F
    |=> (dest_reg >> ($past(source_reg[4:0]) + 6'h1)) == 32'h0)
    else $error("field not zero extended");
  // one wait state keeps the register read path short
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("apb answer late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_clean: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response malformed");
  a_unmapped_err: assert property (psel && penable && pready && paddr > 8'h2C |-> pslverr)
    else $error("unmapped access not refused");
endmodule

/* File: tb/acx_pipe_model.sv */
// pipeline model issuing extract operations and taking results
module acx_pipe_model (
  // clock
  input wire logic clk_sys,
  // request
  output logic op_valid,
  output logic [2:0] op_code,
  output logic [1:0] acc_select,
  output logic [31:0] source_reg,
  output logic [4:0] op_shift_imm,
  // writeback
  input wire logic res_valid,
  input wire logic [31:0] dest_reg,
  input wire logic res_extract_fail
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    op_valid = 1'b0;
    op_code = 3'h0;
    acc_select = 2'h0;
    source_reg = 32'h0;
    op_shift_imm = 5'h0;
  end
  // source_reg and op_shift_imm inverted once taken, so stale values never pass as valid; op_code and acc_select are held
  task automatic issue(input logic [2:0] c, input logic [1:0] a, input logic [31:0] s,
    input logic [4:0] i, output logic [31:0] d, output logic f);
    int n;
    @(posedge clk_sys);
    op_valid <= 1'b1;
    op_code <= c;
    acc_select <= a;
    source_reg <= s;
    op_shift_imm <= i;
    @(posedge clk_sys);
    op_valid <= 1'b0;
    source_reg <= ~s;
    op_shift_imm <= ~i;
    n = 0;
    while (res_valid !== 1'b1 && n < 3)
    begin
      @(posedge clk_sys);
      n++;
    end
    d = dest_reg;
    f = res_extract_fail;
  endtask
endmodule

/* File: tb/testbench.sv */
// self-checking testbench of the accumulator extract unit
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata, source_reg, dest_reg;
  wire pready, pslverr, op_valid, res_valid, res_extract_fail, irq;
  wire [2:0] op_code;
  wire [1:0] acc_select;
  wire [4:0] op_shift_imm;
  int n_mismatch = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] q, d;
  logic e, f, wov;
  logic [5:0] pos;
  logic [63:0] ab = 64'hF0E1_D2C3_B4A5_9687;
  logic [63:0] wa [4] = '{64'hFFFF_FFFF_8000_0000, 64'h0000_0000_FFFF_FFFF,
    64'h8000_0000_0000_0000, 64'h0000_0000_0000_0003};
  logic [4:0] ws [4] = '{5'h00, 5'h01, 5'h1F, 5'h01};
  acx_unit dut (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code), .acc_select(acc_select),
    .source_reg(source_reg), .op_shift_imm(op_shift_imm), .res_valid(res_valid),
    .dest_reg(dest_reg), .res_extract_fail(res_extract_fail), .irq(irq));
  acx_pipe_model u_pipe (.clk_sys(clk_sys), .op_valid(op_valid), .op_code(op_code),
    .acc_select(acc_select), .source_reg(source_reg), .op_shift_imm(op_shift_imm),
    .res_valid(res_valid), .dest_reg(dest_reg), .res_extract_fail(res_extract_fail));
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // word reference on a 65-bit value with one guard bit
  function automatic logic [31:0] wexp(input logic [63:0] a, input logic [4:0] s,
    input logic [2:0] c);
    logic [64:0] t, u;
    t = $signed({a, 1'b0}) >>> s;
    u = t + 65'h1;
    wov = !(t[64:32] == 33'h0 || &t[64:32]) || !(u[64:32] == 33'h0 || &u[64:32]);
    if (c == 3'h5 && !(u[64:32] == 33'h0 || &u[64:32]))
      return u[64] ? 32'h8000_0000 : 32'h7FFF_FFFF;
    return (c == 3'h3) ? t[32:1] : u[32:1];
  endfunction
  task automatic bop(input logic [2:0] c, input logic [4:0] sz);
    logic ok;
    ok = pos >= sz;
    u_pipe.issue(c, 2'h1, {27'h5AA_AAAA, c == 3'h2 ? ~sz : sz}, c == 3'h2 ? sz : ~sz, d, f);
    chk(d, ok ? 32'((ab >> (pos - sz)) & ~(64'hFFFF_FFFF_FFFF_FFFF << (sz + 1))) : 32'h0);
    chk(32'(f), 32'(!ok));
    if (ok && c != 3'h0)
      pos = pos - sz - 6'h1;
    apb(1'b0, 8'h00, 32'h0);
    chk(32'(q[5:0]), 32'(pos));
    chk(32'(q[14]), 32'(!ok));
  endtask
  task automatic t_regs;
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    chk({q[30:0], e}, 32'h1);
    apb(1'b1, 8'h02, 32'h0);
    chk(32'(e), 32'h1);
  endtask
  task automatic t_bits;
    apb(1'b1, 8'h18, ab[31:0]);
    apb(1'b1, 8'h1C, ab[63:32]);
    apb(1'b1, 8'h00, 32'h28);
    pos = 6'h28;
    bop(3'h1, 5'h09);
    bop(3'h0, 5'h1F);
    bop(3'h0, 5'h1E);
    bop(3'h2, 5'h1E);
    bop(3'h1, 5'h00);
    apb(1'b0, 8'h18, 32'h0);
    chk(q, ab[31:0]);
    apb(1'b0, 8'h1C, 32'h0);
    chk(q, ab[63:32]);
  endtask
  task automatic t_word;
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'h10 + 8'(8 * i), wa[i][31:0]);
      apb(1'b1, 8'h14 + 8'(8 * i), wa[i][63:32]);
      for (int c = 3; c < 6; c++)
      begin
        apb(1'b1, 8'h00, 32'h0);
        u_pipe.issue(3'(c), 2'(i), {27'h0, ~ws[i]}, ws[i], d, f);
        chk(d, wexp(wa[i], ws[i], 3'(c)));
        apb(1'b0, 8'h00, 32'h0);
        chk(32'(q[23]), 32'(wov));
      end
    end
    apb(1'b1, 8'h00, 32'h0080_0000);
    u_pipe.issue(3'h3, 2'h3, 32'h0, 5'h01, d, f);
    apb(1'b0, 8'h00, 32'h0);
    chk(32'(q[23]), 32'h1);
  endtask
  task automatic t_irq;
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h08, 32'h3);
    repeat (2) @(posedge clk_sys);
    chk(32'(irq), 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h3);
    repeat (2) @(posedge clk_sys);
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h08, 32'h2);
    u_pipe.issue(3'h0, 2'h0, 32'h1, 5'h0, d, f);
    u_pipe.issue(3'h6, 2'h0, 32'h0, 5'h0, d, f);
    chk({d[30:0], f}, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(32'(irq), 32'h0);
    apb(1'b1, 8'h08, 32'h1);
    repeat (2) @(posedge clk_sys);
    chk(32'(irq), 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h1);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      results();
    end
  end
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_regs();
    t_bits();
    t_word();
    t_irq();
    results();
  end
endmodule
bind acx_unit acx_unit_monitor u_mon (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr),
  .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .op_valid(op_valid), .op_code(op_code), .source_reg(source_reg), .res_valid(res_valid),
  .dest_reg(dest_reg), .res_extract_fail(res_extract_fail));
